// ===== src/aoc_output_ctrl.v
// analog output command: warm-up supply and monitor modes
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "aoc_regs.vh"

module aoc_output_ctrl (
    input wire refClk, // 25 MHz clock
    input wire reset, // synchronous, active high
    input wire clkEn, // freezes all state while low
    input wire [3:0] regAddr, // register index
    input wire [31:0] regWrData, // write data
    input wire regWr, // write strobe
    input wire regRd, // read strobe
    output reg [31:0] regRdData, // read data, cycle after strobe
    input wire [95:0] readingK, // four readings, kelvin, mK
    input wire [95:0] readingC, // four readings, celsius, mC
    input wire [95:0] readingSensor, // four readings, raw units
    input wire allOff, // global all-outputs-off pulse
    input wire powerRestore, // pulse after power is restored
    input wire savedRangeOn, // range state kept across power loss
    output reg signed [15:0] dacOut, // output command, mV
    output wire rangeState // current range setting
);

    //------------------------------------------------------------
    // settings
    //------------------------------------------------------------
    reg [1:0] outputModeCommand;
    reg [2:0] inputSel;
    reg [1:0] units;
    reg bipolar;
    reg continuous;
    reg powerUpEnable;
    reg [6:0] warmPct;
    reg rangeOn;
    reg heating;
    reg [23:0] setpoint;
    reg [23:0] epNeg;
    reg [23:0] epZero;
    reg [23:0] epPos;
    reg signed [15:0] monOut;

    // divider state
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_DONE = 2'h2;
    reg [1:0] divState;
    reg [39:0] divNum;
    reg [24:0] divDen;
    reg [25:0] divRem;
    reg [5:0] divCnt;

    wire modeWarm = (outputModeCommand == `AOC_MODE_WARMUP);
    wire modeMon = (outputModeCommand == `AOC_MODE_MONITOR);
    wire hasInput = (inputSel != `AOC_SEL_NONE);
    assign rangeState = rangeOn;

    //------------------------------------------------------------
    // input selection
    //------------------------------------------------------------
    wire [23:0] chanK [0:3];
    wire [23:0] chanC [0:3];
    wire [23:0] chanS [0:3];
    genvar gi;
    // split the packed reading buses per input
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : gUnpack
            assign chanK[gi] = readingK[gi*24 +: 24];
            assign chanC[gi] = readingC[gi*24 +: 24];
            assign chanS[gi] = readingSensor[gi*24 +: 24];
        end
    endgenerate

    wire [1:0] chanIdx = inputSel[1:0] - 2'h1;
    // feedback always compares in kelvin
    wire [23:0] fbTemp = chanK[chanIdx];
    // monitored value in the chosen units
    wire [23:0] monVal = (units == `AOC_UNITS_C) ? chanC[chanIdx] :
                         (units == `AOC_UNITS_SENSOR) ? chanS[chanIdx] :
                         chanK[chanIdx];

    //------------------------------------------------------------
    // endpoint limiting
    //------------------------------------------------------------
    // clamp a written endpoint into the range of the current units
    function [23:0] clampEp;
        input [23:0] v;
        input [1:0] u;
        reg [23:0] lo;
        reg [23:0] hi;
        begin
            lo = (u == `AOC_UNITS_C) ? `AOC_C_MIN :
                 (u == `AOC_UNITS_SENSOR) ? `AOC_S_MIN : `AOC_K_MIN;
            hi = (u == `AOC_UNITS_C) ? `AOC_C_MAX :
                 (u == `AOC_UNITS_SENSOR) ? `AOC_S_MAX : `AOC_K_MAX;
            if ($signed(v) < $signed(lo))
                clampEp = lo;
            else if ($signed(v) > $signed(hi))
                clampEp = hi;
            else
                clampEp = v;
        end
    endfunction

    //------------------------------------------------------------
    // configuration writes
    //------------------------------------------------------------
    wire wrEn = clkEn & regWr;
    // plain settings and endpoints
    always @(posedge refClk)
    begin
        if (reset)
        begin
            outputModeCommand <= `AOC_MODE_OFF;
            inputSel <= `AOC_SEL_NONE;
            units <= `AOC_UNITS_K;
            bipolar <= 1'b0;
            continuous <= 1'b1;
            powerUpEnable <= 1'b0;
            warmPct <= `AOC_PCT_RESET;
            setpoint <= `AOC_SETPOINT_RESET;
            epNeg <= `AOC_EP_NEG_RESET;
            epZero <= `AOC_EP_ZERO_RESET;
            epPos <= `AOC_EP_POS_RESET;
        end
        else if (wrEn)
        begin
            case (regAddr)
                `AOC_ADDR_CTRL:
                begin
                    outputModeCommand <=
                        regWrData[`AOC_MODE_HI:`AOC_MODE_LO];
                    inputSel <= regWrData[`AOC_SEL_HI:`AOC_SEL_LO];
                    units <= regWrData[`AOC_UNITS_HI:`AOC_UNITS_LO];
                    bipolar <= regWrData[`AOC_BIPOLAR_BIT];
                    continuous <= regWrData[`AOC_CONT_BIT];
                    powerUpEnable <= regWrData[`AOC_PUP_BIT];
                end
                `AOC_ADDR_WARMUP:
                    warmPct <= (regWrData[31:0] > {25'h0, `AOC_PCT_MAX}) ?
                        `AOC_PCT_MAX : regWrData[6:0];
                `AOC_ADDR_SETPOINT:
                    setpoint <= regWrData[23:0];
                `AOC_ADDR_EP_NEG:
                    epNeg <= clampEp(regWrData[23:0], units);
                `AOC_ADDR_EP_ZERO:
                    epZero <= clampEp(regWrData[23:0], units);
                `AOC_ADDR_EP_POS:
                    epPos <= clampEp(regWrData[23:0], units);
                default:
                    setpoint <= setpoint;
            endcase
        end
    end

    //------------------------------------------------------------
    // warm-up supply control
    //------------------------------------------------------------
    wire atSetpoint = ($signed(fbTemp) >= $signed(setpoint));
    wire [24:0] lowEdge = {setpoint[23], setpoint} -
                          {1'b0, `AOC_HYST}; // hysteresis is positive
    wire belowHyst = ($signed({fbTemp[23], fbTemp}) <= $signed(lowEdge));
    wire rangeWr = wrEn & (regAddr == `AOC_ADDR_RANGE);

    // range setting and heating phase
    always @(posedge refClk)
    begin
        if (reset)
        begin
            rangeOn <= 1'b0;
            heating <= 1'b0;
        end
        else if (clkEn)
        begin
            if (rangeWr)
            begin
                // software write wins over automatic switch-off
                rangeOn <= regWrData[0];
                heating <= regWrData[0];
            end
            else if (powerRestore)
            begin
                rangeOn <= powerUpEnable & savedRangeOn;
                heating <= powerUpEnable & savedRangeOn;
            end
            else if (allOff && modeWarm)
                rangeOn <= 1'b0;
            else if (modeWarm && rangeOn && hasInput)
            begin
                if (!continuous)
                begin
                    if (heating && atSetpoint)
                    begin
                        heating <= 1'b0;
                        rangeOn <= 1'b0;
                    end
                end
                else if (atSetpoint)
                    heating <= 1'b0;
                else if (belowHyst)
                    heating <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // monitor scaling
    //------------------------------------------------------------
    wire [23:0] epLow = bipolar ? epNeg : epZero;
    wire [24:0] diff = {monVal[23], monVal} - {epLow[23], epLow};
    wire [24:0] den = {epPos[23], epPos} - {epLow[23], epLow};
    wire [14:0] span = bipolar ? `AOC_SPAN_BI : `AOC_SPAN_UNI;
    wire [15:0] railLow = bipolar ? `AOC_RAIL_NEG : `AOC_RAIL_ZERO;
    wire [39:0] product = diff[23:0] * span;
    wire [25:0] trial = {divRem[24:0], divNum[39]};
    wire fits = (trial >= {1'b0, divDen});

    // long division of (reading - low) * span by (high - low)
    always @(posedge refClk)
    begin
        if (reset)
        begin
            divState <= ST_IDLE;
            divNum <= 40'h0;
            divDen <= 25'h0;
            divRem <= 26'h0;
            divCnt <= 6'h0;
            monOut <= 16'h0000;
        end
        else if (clkEn)
        begin
            case (divState)
                ST_IDLE:
                begin
                    if (!modeMon || !hasInput)
                        monOut <= `AOC_RAIL_ZERO;
                    else if ($signed(den) <= $signed(25'h0) ||
                             $signed(diff) <= $signed(25'h0))
                        monOut <= railLow;
                    else if ($signed(diff) >= $signed(den))
                        monOut <= `AOC_RAIL_POS;
                    else
                    begin
                        divNum <= product;
                        divDen <= den;
                        divRem <= 26'h0;
                        divCnt <= `AOC_DIV_STEPS;
                        divState <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    divRem <= fits ? (trial - {1'b0, divDen}) : trial;
                    divNum <= {divNum[38:0], fits};
                    divCnt <= divCnt - 6'h1;
                    if (divCnt == 6'h1)
                        divState <= ST_DONE;
                end
                ST_DONE:
                begin
                    monOut <= railLow + divNum[15:0];
                    divState <= ST_IDLE;
                end
                default:
                    divState <= ST_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------
    // output command
    //------------------------------------------------------------
    wire [13:0] warmMv = warmPct * `AOC_MV_PER_PCT;
    // pick the command for the active mode
    always @(posedge refClk)
    begin
        if (reset)
            dacOut <= 16'h0000;
        else if (clkEn)
        begin
            if (modeWarm)
                dacOut <= (rangeOn && heating && hasInput) ?
                    {2'h0, warmMv} : `AOC_RAIL_ZERO;
            else if (modeMon)
                dacOut <= monOut;
            else
                dacOut <= `AOC_RAIL_ZERO;
        end
    end

    //------------------------------------------------------------
    // register reads
    //------------------------------------------------------------
    reg [31:0] next_regRdData;
    // decode the read address; unmapped reads give zero
    always @*
    begin
        next_regRdData = 32'h00000000;
        case (regAddr)
            `AOC_ADDR_CTRL:
                next_regRdData = {22'h0, powerUpEnable, continuous,
                    bipolar, units, inputSel, outputModeCommand};
            `AOC_ADDR_WARMUP:
                next_regRdData = {25'h0, warmPct};
            `AOC_ADDR_RANGE:
                next_regRdData = {31'h0, rangeOn};
            `AOC_ADDR_SETPOINT:
                next_regRdData = {8'h00, setpoint};
            `AOC_ADDR_EP_NEG:
                next_regRdData = {8'h00, epNeg};
            `AOC_ADDR_EP_ZERO:
                next_regRdData = {8'h00, epZero};
            `AOC_ADDR_EP_POS:
                next_regRdData = {8'h00, epPos};
            `AOC_ADDR_STATUS:
                next_regRdData = {29'h0, (divState != ST_IDLE),
                    rangeOn, heating};
            `AOC_ADDR_DAC:
                next_regRdData = {{16{dacOut[15]}}, dacOut};
            default:
                next_regRdData = 32'h00000000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always @(posedge refClk)
    begin
        if (reset)
            regRdData <= 32'h00000000;
        else if (clkEn)
            regRdData <= regRd ? next_regRdData : 32'h00000000;
    end

endmodule

// ===== src/aoc_regs.vh
// register map, field layout, reset values and limits of the output control
`ifndef AOC_REGS_VH
`define AOC_REGS_VH

// register indices on the plain register port
`define AOC_ADDR_CTRL 4'h0
`define AOC_ADDR_WARMUP 4'h1
`define AOC_ADDR_RANGE 4'h2
`define AOC_ADDR_SETPOINT 4'h3
`define AOC_ADDR_EP_NEG 4'h4
`define AOC_ADDR_EP_ZERO 4'h5
`define AOC_ADDR_EP_POS 4'h6
`define AOC_ADDR_STATUS 4'h7
`define AOC_ADDR_DAC 4'h8

// control register fields
`define AOC_MODE_LO 0
`define AOC_MODE_HI 1
`define AOC_SEL_LO 2
`define AOC_SEL_HI 4
`define AOC_UNITS_LO 5
`define AOC_UNITS_HI 6
`define AOC_BIPOLAR_BIT 7
`define AOC_CONT_BIT 8
`define AOC_PUP_BIT 9

// output modes
`define AOC_MODE_OFF 2'h0
`define AOC_MODE_MONITOR 2'h1
`define AOC_MODE_WARMUP 2'h2

// input choices and units
`define AOC_SEL_NONE 3'h0
`define AOC_UNITS_K 2'h0
`define AOC_UNITS_C 2'h1
`define AOC_UNITS_SENSOR 2'h2

// reset values (temperatures in millikelvin, 1 LSB = 0.001 unit)
`define AOC_PCT_RESET 7'h64
`define AOC_PCT_MAX 7'h64
`define AOC_EP_NEG_RESET 24'h000000
`define AOC_EP_ZERO_RESET 24'h000000
`define AOC_EP_POS_RESET 24'h0F4240
`define AOC_SETPOINT_RESET 24'h000000

// 1 K hysteresis for continuous control
`define AOC_HYST 24'h0003E8

// endpoint limits per unit, signed 24 bit
`define AOC_K_MIN 24'h000000
`define AOC_K_MAX 24'h1E8480
`define AOC_C_MIN 24'hFBD502
`define AOC_C_MAX 24'h1A58C2
`define AOC_S_MIN 24'h000000
`define AOC_S_MAX 24'h7FFFFF

// output scale in millivolts
`define AOC_MV_PER_PCT 8'h64
`define AOC_SPAN_UNI 15'h2710
`define AOC_SPAN_BI 15'h4E20
`define AOC_RAIL_NEG 16'hD8F0
`define AOC_RAIL_ZERO 16'h0000
`define AOC_RAIL_POS 16'h2710

// divider length in cycles
`define AOC_DIV_STEPS 6'h28

`endif

// ===== verification/aoc_output_ctrl_asserts.sv
// port checker for the analog output control
`timescale 1ns/100ps
module aoc_output_ctrl_asserts (
    input wire refClk, // clock
    input wire reset, // sync reset
    input wire clkEn, // clock enable
    input wire [3:0] regAddr, // register index
    input wire [31:0] regWrData, // write data
    input wire regWr, // write strobe
    input wire regRd, // read strobe
    input wire [31:0] regRdData, // read data
    input wire allOff, // all-outputs-off
    input wire powerRestore, // power back
    input wire signed [15:0] dacOut, // command, mV
    input wire rangeState // range setting
);
reg [1:0] mode;
reg cont;
reg [6:0] pct;
wire rngWr = clkEn && regWr && regAddr == 4'h2;
// shadow of mode, control style and percentage
always @(posedge refClk)
begin
    if (reset)
    begin
        mode <= 2'h0;
        cont <= 1'b1;
        pct <= 7'h64;
    end
    else if (clkEn && regWr && regAddr == 4'h0)
    begin
        mode <= regWrData[1:0];
        cont <= regWrData[8];
    end
    else if (clkEn && regWr && regAddr == 4'h1)
        pct <= (regWrData > 32'h64) ? 7'h64 : regWrData[6:0];
end
// ----------------------------------------
// properties
// ----------------------------------------
default clocking @(posedge refClk); endclocking
default disable iff (reset);
chk_dac_in_rails: assert property (
    dacOut >= $signed(16'hD8F0) && dacOut <= $signed(16'h2710))
    else $error("dac outside rails");
chk_warm_level: assert property (
    $past(mode) == 2'h2 |-> dacOut == 16'h0 || dacOut == $past(pct) * 16'h64)
    else $error("warm-up level wrong");
chk_range_zero: assert property (
    $past(mode) == 2'h2 && !$past(rangeState) |-> dacOut == 16'h0)
    else $error("output on while range off");
chk_range_set: assert property (
    rngWr && regWrData[0] |=> rangeState)
    else $error("range write not taken");
chk_cont_keeps: assert property (
    rangeState && cont && mode == 2'h2 && !allOff && !regWr && !powerRestore
    |=> rangeState)
    else $error("continuous cleared range");
chk_fall_zero: assert property (
    $fell(rangeState) && mode == 2'h2 && clkEn |=> dacOut == 16'h0)
    else $error("output on after switch-off");
chk_alloff_warm: assert property (
    clkEn && allOff && mode == 2'h2 && !rngWr && !powerRestore
    |=> !rangeState)
    else $error("all-off ignored in warm-up");
chk_status_read: assert property (
    clkEn && regRd && regAddr == 4'h7 |=> regRdData[1] == $past(rangeState))
    else $error("status range bit wrong");
cover property (rngWr && regWrData[0]);
cover property ($fell(rangeState) && mode == 2'h2);
cover property (mode == 2'h1 && dacOut == $signed(16'hD8F0));
endmodule
bind aoc_output_ctrl aoc_output_ctrl_asserts u_chk (.refClk(refClk),
    .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .allOff(allOff),
    .powerRestore(powerRestore), .dacOut(dacOut), .rangeState(rangeState));

// ===== verification/aoc_far_end.sv
// far-side model: plant readings and external supply
`timescale 1ns/100ps
module aoc_far_end (
    input wire refClk, // clock
    input wire [23:0] tempMk, // plant temperature, mK
    input wire signed [15:0] dacOut, // command, mV
    output wire [95:0] readingK, // kelvin readings
    output wire [95:0] readingC, // celsius readings
    output wire [95:0] readingSensor, // raw readings
    output reg supplyOn // supply running
);
// input A sees the plant, B to D sit 100 K hotter in kelvin and raw units; celsius reads the plant on all four; raw A reads double
wire [23:0] hot = tempMk + 24'h0186A0;
wire [23:0] cel = tempMk - 24'h042AFE;
assign readingK = {hot, hot, hot, tempMk};
assign readingSensor = {hot, hot, hot, tempMk + tempMk};
assign readingC = {cel, cel, cel, cel};
// supply runs while commanded above zero
always @(posedge refClk)
    supplyOn <= dacOut > $signed(16'h0000);
endmodule

// ===== verification/tb_top.sv
// self-checking testbench for the analog output control
`timescale 1ns/100ps
module tb_top;
reg refClk, reset, regWr, regRd, allOff, powerRestore, savedRangeOn;
reg clkEn;
reg [3:0] regAddr;
reg [31:0] regWrData;
reg [23:0] tempMk;
wire [31:0] regRdData;
wire [95:0] readingK, readingC, readingSensor;
wire signed [15:0] dacOut;
wire rangeState, supplyOn;
integer errorCnt, totalChecks, i;
aoc_output_ctrl dut (.refClk(refClk), .reset(reset), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .readingK(readingK), .readingC(readingC),
    .readingSensor(readingSensor), .allOff(allOff),
    .powerRestore(powerRestore), .savedRangeOn(savedRangeOn),
    .dacOut(dacOut), .rangeState(rangeState));
aoc_far_end far (.refClk(refClk), .tempMk(tempMk), .dacOut(dacOut),
    .readingK(readingK), .readingC(readingC),
    .readingSensor(readingSensor), .supplyOn(supplyOn));
// ----------------------------------------
// tasks
// ----------------------------------------
task check(input [31:0] nm, input [31:0] seen, input [31:0] exp);
begin
    totalChecks = totalChecks + 1;
    if (seen !== exp)
    begin
        errorCnt = errorCnt + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
    end
end
endtask
task cyc(input integer n);
begin
    repeat (n) @(posedge refClk);
    #1; // look after the outputs have settled
end
endtask
task wr(input [3:0] a, input [31:0] d);
begin
    @(posedge refClk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge refClk);
    regWr <= 1'b0;
end
endtask
task rd(input [3:0] a, input [31:0] e);
begin
    @(posedge refClk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge refClk);
    regRd <= 1'b0;
    #1 check("reg", regRdData, e);
end
endtask
task dac(input [15:0] e);
    check("dac", {16'h0, dacOut}, {16'h0, e});
endtask
task rng(input e);
    check("rng", {31'h0, rangeState}, {31'h0, e});
endtask
task setT(input [23:0] t, input integer n);
begin
    @(posedge refClk);
    tempMk <= t;
    cyc(n);
end
endtask
task pulse(input s);
begin
    @(posedge refClk);
    allOff <= s;
    powerRestore <= !s;
    @(posedge refClk);
    allOff <= 1'b0;
    powerRestore <= 1'b0;
    cyc(3);
end
endtask
task reportAndStop;
begin
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
end
endtask
// ----------------------------------------
// clock, watchdog, main sequence
// ----------------------------------------
initial
begin
    refClk = 1'b0;
    forever #20 refClk = ~refClk;
end
initial
begin
    repeat (5000) @(posedge refClk);
    errorCnt = errorCnt + 1;
    reportAndStop;
end
initial
begin
    errorCnt = 0;
    totalChecks = 0;
    {reset, regWr, regRd, allOff, powerRestore, savedRangeOn} = 6'h20;
    regAddr = 4'h0;
    regWrData = 32'h0;
    tempMk = 24'h046CD0;
    clkEn = 1'b1;
    repeat (20) @(posedge refClk);
    reset <= 1'b0;
    // defaults, unmapped places read zero
    for (i = 0; i < 16; i = i + 1)
        rd(i[3:0], i == 0 ? 32'h100 : i == 1 ? 32'h64 :
            i == 6 ? 32'hF4240 : 32'h0);
    // a write while the clock enable is low is lost
    @(posedge refClk);
    clkEn <= 1'b0;
    wr(4'h1, 32'h0);
    clkEn <= 1'b1;
    rd(4'h1, 32'h64);
    wr(4'h4, 32'hFFFFFB);
    rd(4'h4, 32'h0);
    wr(4'h6, 32'h2DC6C0);
    rd(4'h6, 32'h1E8480);
    wr(4'h1, 32'h7F);
    rd(4'h1, 32'h64);
    // continuous warm-up at 50 %, setpoint 300 K
    wr(4'h1, 32'h32);
    wr(4'h3, 32'h493E0);
    wr(4'h0, 32'h106);
    cyc(3);
    dac(16'h0);
    wr(4'h2, 32'h1);
    cyc(3);
    dac(16'h1388);
    check("sup", {31'h0, supplyOn}, 32'h1);
    setT(24'h0493E0, 4);
    dac(16'h0);
    rng(1'b1);
    setT(24'h0491EC, 4);
    dac(16'h0);
    setT(24'h048FF8, 4);
    dac(16'h1388);
    rd(4'h7, 32'h3);
    wr(4'h0, 32'h10A);
    cyc(4);
    dac(16'h0);
    pulse(1'b1);
    rng(1'b0);
    // auto-off at full percentage
    wr(4'h0, 32'h006);
    wr(4'h1, 32'h64);
    setT(24'h046CD0, 2);
    wr(4'h2, 32'h1);
    cyc(3);
    dac(16'h2710);
    setT(24'h0493E0, 4);
    dac(16'h0);
    rng(1'b0);
    setT(24'h046CD0, 4);
    dac(16'h0);
    wr(4'h2, 32'h1);
    cyc(3);
    dac(16'h2710);
    // power-up enable decides the range after restore
    wr(4'h2, 32'h0);
    wr(4'h0, 32'h206);
    savedRangeOn <= 1'b1;
    pulse(1'b0);
    rng(1'b1);
    wr(4'h0, 32'h006);
    pulse(1'b0);
    rng(1'b0);
    // monitor, +10 V at 100 K
    wr(4'h6, 32'h186A0);
    wr(4'h0, 32'h001);
    setT(24'h00C350, 100);
    dac(16'h0);
    wr(4'h0, 32'h005);
    cyc(100);
    dac(16'h1388);
    pulse(1'b1);
    dac(16'h1388);
    wr(4'h0, 32'h085);
    cyc(100);
    dac(16'h0);
    setT(24'h0061A8, 100);
    dac(16'hEC78);
    setT(24'h0, 100);
    dac(16'hD8F0);
    setT(24'h0186A0, 100);
    dac(16'h2710);
    setT(24'h0249F0, 100);
    dac(16'h2710);
    // celsius span 0 C to 100 C, reading 50 C
    wr(4'h0, 32'h025);
    setT(24'h04EE4E, 100);
    dac(16'h1388);
    rd(4'h8, 32'h1388);
    // celsius limits: a deep negative endpoint is clamped
    wr(4'h4, 32'hF00000);
    rd(4'h4, 32'hFBD502);
    // raw sensor units, reading 50000 against a 0..100000 span
    wr(4'h0, 32'h045);
    setT(24'h0061A8, 100);
    dac(16'h1388);
    reportAndStop;
end
endmodule
